// File: design/ispgc_pkg.sv
// Function
// - Write-direction match clears direction, buffers address
// - No acknowledge when buffer full or overflow
// - Load buffer only when buffer full clear
// - Flag every received byte; software clears it
// - Read match sets direction, acknowledges, stretches clock
// - Buffer write loads shifter; clock_release frees clock
// - Transmit bits change on falling clock edges
// - Transmit flag set at ninth falling edge
// - Master not-acknowledge ends transfer, resets slave
// - General call recognised only when enabled
// - Address compared to own and general call
// - General call buffers byte, flags ninth edge
// - Ten-bit address match sets address_update_needed
// - Ten-bit general call skips second address half
// - Wake sleeping processor when serial interrupt enabled
// - Reset disables port, aborts transfer
// - Start/stop seen cleared on reset, disable
// - Bus free when stop seen or both clear
// - Master mode flags start and stop conditions only; no bytes are received
// - Reset zeroes control, control two, status
// - Sample on rise, compare at eighth fall
// - Buffer read clears buffer_full; overflow sticky
package ispgc_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS_ONE = 8'h0c;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS_TWO = 8'h0d;
  localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h13;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h14;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES_ONE = 8'h8c;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES_TWO = 8'h8d;
  localparam logic [7:0] IDX_SERIAL_CONTROL_TWO = 8'h91;
  localparam logic [7:0] IDX_OWN_ADDRESS = 8'h93;
  localparam logic [7:0] IDX_SERIAL_STATUS = 8'h94;

  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_INTERRUPT_CONTROL = 12'h02c;
  localparam logic [11:0] ADDR_PERIPHERAL_FLAGS_ONE = 12'h030;
  localparam logic [11:0] ADDR_PERIPHERAL_FLAGS_TWO = 12'h034;
  localparam logic [11:0] ADDR_SERIAL_BUFFER = 12'h04c;
  localparam logic [11:0] ADDR_SERIAL_CONTROL = 12'h050;
  localparam logic [11:0] ADDR_PERIPHERAL_ENABLES_ONE = 12'h230;
  localparam logic [11:0] ADDR_PERIPHERAL_ENABLES_TWO = 12'h234;
  localparam logic [11:0] ADDR_SERIAL_CONTROL_TWO = 12'h244;
  localparam logic [11:0] ADDR_OWN_ADDRESS = 12'h24c;
  localparam logic [11:0] ADDR_SERIAL_STATUS = 12'h250;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_BUFFER_FULL = 0;
  localparam int STAT_ADDRESS_UPDATE = 1;
  localparam int STAT_DIRECTION = 2;
  localparam int STAT_START_SEEN = 3;
  localparam int STAT_STOP_SEEN = 4;
  localparam int STAT_DATA_NOT_ADDR = 5;
  localparam int CTL_WRITE_COLLISION = 7;
  localparam int CTL_RECEIVE_OVERFLOW = 6;
  localparam int CTL_ENABLE = 5;
  localparam int CTL_CLOCK_RELEASE = 4;
  localparam int CTL2_GENERAL_CALL_ENABLE = 7;
  localparam int FLAG_SERIAL_IRQ = 3;
  localparam int MODE_TEN_BIT = 0;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] GENERAL_CALL_ADDRESS = 8'h00;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_PULSE = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_RX,
    ST_TX
  } ispgc_state_t;

endpackage : ispgc_pkg

// File: design/ispgc_sync.sv
`timescale 1ns/1ns
module ispgc_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      meta_q <= '1;
      o_sync <= '1;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : ispgc_sync

// File: design/ispgc_slave.sv
`timescale 1ns/1ns
module ispgc_slave (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // AXI4-Lite write
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Two-wire bus
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // System
  input wire logic i_sleep,
  output logic o_wake,
  output logic o_bus_free
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [11:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic wr_fire, rd_fire, wr_hit;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_buf, wr_ctl, wr_ctl2, wr_stat, wr_own, wr_flags, wr_pie;
  logic rd_buf;
  logic [7:0] buf_q, own_q, ctl2_q, flags_q, pie_q;
  logic bf_q, ua_q, rw_q, start_q, stop_q, da_q;
  logic [1:0] stat_hi_q;
  logic wcol_q, ov_q, en_q, ckp_q;
  logic [3:0] mode_q;
  logic [1:0] bus_s;
  logic scl_s, sda_s, scl_d, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;
  ispgc_pkg::ispgc_state_t state_q;
  logic [7:0] sr_q;
  logic [3:0] cnt_q;
  logic hold_q, tx_next_q, nack_q, stage_q, addressed_q, acc_q;
  logic byte_end, ack_end, own7, m_gc, match, accept, is_read;
  logic ev_load, ev_ack, ev_ov, ev_ua, ev_addr, ev_irq, ev_ckp_clr;
  logic tenbit, master;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign wr_fire = ~o_awready & ~o_wready & ~o_bvalid;
  assign rd_fire = i_arvalid & o_arready;
  assign wr_buf = wr_fire & wstrb0_q
    & (awaddr_q == ispgc_pkg::ADDR_SERIAL_BUFFER);
  assign wr_ctl = wr_fire & wstrb0_q
    & (awaddr_q == ispgc_pkg::ADDR_SERIAL_CONTROL);
  assign wr_ctl2 = wr_fire & wstrb0_q
    & (awaddr_q == ispgc_pkg::ADDR_SERIAL_CONTROL_TWO);
  assign wr_stat = wr_fire & wstrb0_q
    & (awaddr_q == ispgc_pkg::ADDR_SERIAL_STATUS);
  assign wr_own = wr_fire & wstrb0_q
    & (awaddr_q == ispgc_pkg::ADDR_OWN_ADDRESS);
  assign wr_flags = wr_fire & wstrb0_q
    & (awaddr_q == ispgc_pkg::ADDR_PERIPHERAL_FLAGS_ONE);
  assign wr_pie = wr_fire & wstrb0_q
    & (awaddr_q == ispgc_pkg::ADDR_PERIPHERAL_ENABLES_ONE);
  assign rd_buf = rd_fire & (i_araddr == ispgc_pkg::ADDR_SERIAL_BUFFER);

  always_comb
  begin
    wr_hit = 1'b1;
    case (awaddr_q)
      ispgc_pkg::ADDR_INTERRUPT_CONTROL,
      ispgc_pkg::ADDR_PERIPHERAL_FLAGS_ONE,
      ispgc_pkg::ADDR_PERIPHERAL_FLAGS_TWO,
      ispgc_pkg::ADDR_SERIAL_BUFFER,
      ispgc_pkg::ADDR_SERIAL_CONTROL,
      ispgc_pkg::ADDR_PERIPHERAL_ENABLES_ONE,
      ispgc_pkg::ADDR_PERIPHERAL_ENABLES_TWO,
      ispgc_pkg::ADDR_SERIAL_CONTROL_TWO,
      ispgc_pkg::ADDR_OWN_ADDRESS,
      ispgc_pkg::ADDR_SERIAL_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (i_araddr)
      ispgc_pkg::ADDR_INTERRUPT_CONTROL,
      ispgc_pkg::ADDR_PERIPHERAL_FLAGS_TWO,
      ispgc_pkg::ADDR_PERIPHERAL_ENABLES_TWO: rd_data[7:0] = 8'h00;
      ispgc_pkg::ADDR_PERIPHERAL_FLAGS_ONE: rd_data[7:0] = flags_q;
      ispgc_pkg::ADDR_PERIPHERAL_ENABLES_ONE: rd_data[7:0] = pie_q;
      ispgc_pkg::ADDR_SERIAL_BUFFER: rd_data[7:0] = buf_q;
      ispgc_pkg::ADDR_SERIAL_CONTROL:
        rd_data[7:0] = {wcol_q, ov_q, en_q, ckp_q, mode_q};
      ispgc_pkg::ADDR_SERIAL_CONTROL_TWO: rd_data[7:0] = ctl2_q;
      ispgc_pkg::ADDR_OWN_ADDRESS: rd_data[7:0] = own_q;
      ispgc_pkg::ADDR_SERIAL_STATUS:
        rd_data[7:0] = {stat_hi_q, da_q, stop_q, start_q, rw_q, ua_q, bf_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= ispgc_pkg::RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      if (i_awvalid & o_awready)
      begin
        o_awready <= 1'b0;
        awaddr_q <= i_awaddr;
      end
      if (i_wvalid & o_wready)
      begin
        o_wready <= 1'b0;
        wdata_q <= i_wdata[7:0];
        wstrb0_q <= i_wstrb[0];
      end
      if (wr_fire)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_hit ? ispgc_pkg::RESP_OKAY : ispgc_pkg::RESP_SLVERR;
      end
      if (o_bvalid & i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= ispgc_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_data;
      o_rresp <= rd_hit ? ispgc_pkg::RESP_OKAY : ispgc_pkg::RESP_SLVERR;
    end
    else if (o_rvalid & i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      wcol_q <= 1'b0;
      en_q <= 1'b0;
      mode_q <= 4'h0;
      ctl2_q <= ispgc_pkg::RESET_ZERO;
      stat_hi_q <= 2'b00;
      own_q <= ispgc_pkg::RESET_ZERO;
      pie_q <= ispgc_pkg::RESET_ZERO;
    end
    else
    begin
      if (wr_ctl)
      begin
        wcol_q <= wdata_q[ispgc_pkg::CTL_WRITE_COLLISION];
        en_q <= wdata_q[ispgc_pkg::CTL_ENABLE];
        mode_q <= wdata_q[3:0];
      end
      if (wr_ctl2)
        ctl2_q <= wdata_q;
      if (wr_stat)
        stat_hi_q <= wdata_q[7:6];
      if (wr_own)
        own_q <= wdata_q;
      if (wr_pie)
        pie_q <= wdata_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus input synchronisers and edges
  // ----------------------------------------------------------------
  ispgc_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async({i_scl, i_sda}),
    .o_sync(bus_s)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Address match and byte events
  // ----------------------------------------------------------------
  assign tenbit = mode_q[ispgc_pkg::MODE_TEN_BIT];
  assign master = (mode_q == ispgc_pkg::MODE_MASTER);
  assign byte_end = scl_fall & (cnt_q == ispgc_pkg::BITS_PER_BYTE)
    & (state_q != ispgc_pkg::ST_IDLE);
  assign ack_end = scl_fall & (cnt_q == ispgc_pkg::ACK_PULSE)
    & acc_q;
  assign own7 = (sr_q[7:1] == own_q[7:1]);
  assign m_gc = ctl2_q[ispgc_pkg::CTL2_GENERAL_CALL_ENABLE]
    & (sr_q == ispgc_pkg::GENERAL_CALL_ADDRESS);

  always_comb
  begin
    match = 1'b0;
    if (tenbit & stage_q)
      match = (sr_q == own_q);
    else if (tenbit)
      match = m_gc | (own7 & (~sr_q[0] | addressed_q));
    else
      match = m_gc | own7;
  end

  assign is_read = match & sr_q[0] & ~m_gc;
  assign accept = (state_q == ispgc_pkg::ST_RX) | match;
  assign ev_addr = byte_end & (state_q == ispgc_pkg::ST_ADDR) & match;
  assign ev_load = byte_end & (state_q != ispgc_pkg::ST_TX)
    & accept & ~bf_q;
  assign ev_ack = ev_load & ~ov_q;
  assign ev_ov = byte_end & (state_q != ispgc_pkg::ST_TX) & accept & bf_q;
  assign ev_ua = ev_addr & tenbit & ~m_gc & ~sr_q[0];
  assign ev_irq = ack_end | (master & (start_det | stop_det));
  assign ev_ckp_clr = ack_end & tx_next_q & ~nack_q;

  // ----------------------------------------------------------------
  // Status and flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      bf_q <= 1'b0;
      ov_q <= 1'b0;
      ua_q <= 1'b0;
      rw_q <= 1'b0;
      da_q <= 1'b0;
      ckp_q <= 1'b0;
      buf_q <= 8'h00;
    end
    else
    begin
      if (ev_load)
      begin
        bf_q <= 1'b1;
        buf_q <= sr_q;
      end
      else if (rd_buf)
        bf_q <= 1'b0;
      else if (wr_buf)
        buf_q <= wdata_q;
      if (ev_ov)
        ov_q <= 1'b1;
      else if (wr_ctl)
        ov_q <= wdata_q[ispgc_pkg::CTL_RECEIVE_OVERFLOW];
      if (ev_ua)
        ua_q <= 1'b1;
      else if (wr_own)
        ua_q <= 1'b0;
      if (ev_addr)
        rw_q <= is_read;
      if (byte_end)
        da_q <= (state_q == ispgc_pkg::ST_RX);
      if (wr_ctl)
        ckp_q <= wdata_q[ispgc_pkg::CTL_CLOCK_RELEASE];
      else if (ev_ckp_clr)
        ckp_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      flags_q <= ispgc_pkg::RESET_ZERO;
    else if (en_q & ev_irq)
    begin
      if (wr_flags)
        flags_q <= wdata_q;
      flags_q[ispgc_pkg::FLAG_SERIAL_IRQ] <= 1'b1;
    end
    else if (wr_flags)
      flags_q <= wdata_q;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset | ~en_q)
    begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else if (start_det)
    begin
      start_q <= 1'b1;
      stop_q <= 1'b0;
    end
    else if (stop_det)
    begin
      start_q <= 1'b0;
      stop_q <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_bus_free <= 1'b0;
      o_wake <= 1'b0;
    end
    else
    begin
      o_bus_free <= stop_q | (~start_q & ~stop_q);
      o_wake <= i_sleep & pie_q[ispgc_pkg::FLAG_SERIAL_IRQ]
        & flags_q[ispgc_pkg::FLAG_SERIAL_IRQ];
    end
  end

  // ----------------------------------------------------------------
  // Slave engine
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_reset | ~en_q | stop_det)
    begin
      state_q <= ispgc_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      hold_q <= 1'b0;
      tx_next_q <= 1'b0;
      nack_q <= 1'b0;
      acc_q <= 1'b0;
      stage_q <= 1'b0;
      addressed_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else if (start_det & ~master)
    begin
      state_q <= ispgc_pkg::ST_ADDR;
      cnt_q <= 4'h0;
      hold_q <= 1'b0;
      tx_next_q <= 1'b0;
      nack_q <= 1'b0;
      acc_q <= 1'b0;
      stage_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else if (hold_q)
    begin
      if (tx_next_q & ckp_q)
      begin
        hold_q <= 1'b0;
        state_q <= ispgc_pkg::ST_TX;
        o_sda_oe <= ~sr_q[7];
      end
      else if (~tx_next_q & ~ua_q)
        hold_q <= 1'b0;
    end
    else if (state_q != ispgc_pkg::ST_IDLE)
    begin
      if (scl_rise)
      begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == ispgc_pkg::BITS_PER_BYTE)
          nack_q <= sda_s;
      end
      if (byte_end)
      begin
        acc_q <= accept | (state_q == ispgc_pkg::ST_TX);
        if (state_q == ispgc_pkg::ST_TX)
          o_sda_oe <= 1'b0;
        else
          o_sda_oe <= ev_ack;
        if (state_q == ispgc_pkg::ST_ADDR)
        begin
          if (~match)
            state_q <= ispgc_pkg::ST_IDLE;
          else if (is_read)
            tx_next_q <= 1'b1;
          else if (tenbit & ~m_gc & ~stage_q)
            stage_q <= 1'b1;
          else
          begin
            addressed_q <= tenbit & ~m_gc;
            state_q <= ispgc_pkg::ST_RX;
          end
        end
      end
      else if (ack_end)
      begin
        cnt_q <= 4'h0;
        o_sda_oe <= 1'b0;
        if (tx_next_q & nack_q & (state_q == ispgc_pkg::ST_TX))
        begin
          state_q <= ispgc_pkg::ST_IDLE;
          tx_next_q <= 1'b0;
        end
        else
          hold_q <= tx_next_q | ua_q;
      end
      else if (scl_fall & (state_q == ispgc_pkg::ST_TX)
        & (cnt_q != 4'h0) & (cnt_q < ispgc_pkg::BITS_PER_BYTE))
        o_sda_oe <= ~sr_q[6];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      sr_q <= 8'h00;
    else if (wr_buf & (state_q == ispgc_pkg::ST_TX | tx_next_q))
      sr_q <= wdata_q;
    else if (scl_rise & (state_q == ispgc_pkg::ST_ADDR
      | state_q == ispgc_pkg::ST_RX) & ~hold_q)
      sr_q <= {sr_q[6:0], sda_s};
    else if (scl_fall & (state_q == ispgc_pkg::ST_TX)
      & (cnt_q != 4'h0) & (cnt_q < ispgc_pkg::BITS_PER_BYTE))
      sr_q <= {sr_q[6:0], 1'b0};
  end

  // ----------------------------------------------------------------
  // Open-drain line drivers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_scl_oe <= 1'b0;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
    end
    else
    begin
      o_scl_oe <= hold_q & en_q;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
    end
  end

endmodule : ispgc_slave

// File: bench/ispgc_properties.sv
`timescale 1ns/1ns
module ispgc_properties (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  // Two-wire bus and system
  input wire logic i_scl,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_sleep,
  input wire logic o_wake,
  input wire logic o_bus_free
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  // ----
  // Properties
  // ----
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence
  AST_OPEN_DRAIN:
    assert property (!o_scl_out && !o_sda_out) else $error("line high");
  AST_RESET_QUIET:
    assert property (disable iff (1'b0) i_reset |=> !o_scl_oe &&
      !o_sda_oe && !o_bvalid && !o_rvalid) else $error("reset busy");
  AST_FREE_AFTER_RESET:
    assert property ($fell(i_reset) |=> o_bus_free) else $error("not free");
  AST_WAKE_SLEEP:
    assert property (o_wake |-> $past(i_sleep)) else $error("wake awake");
  AST_STRETCH_LOW:
    assert property ($rose(o_scl_oe) |-> !$past(i_scl))
      else $error("bad stretch");
  AST_TX_CHANGE:
    assert property ($changed(o_sda_oe) |-> !i_scl) else $error("sda moved");
  AST_RD_ANSWER:
    assert property (s_rd_taken |=> o_rvalid && o_rdata[31:8] == 24'h000000)
      else $error("read answer");
  AST_WR_ANSWER:
    assert property (s_wr_taken |-> ##[1:2] o_bvalid) else $error("no bvalid");
endmodule : ispgc_properties

bind ispgc_slave ispgc_properties i_ispgc_properties (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_scl(i_scl),
  .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .i_sleep(i_sleep), .o_wake(o_wake),
  .o_bus_free(o_bus_free)
);

// File: bench/ispgc_bus_model.sv
`timescale 1ns/1ns
module ispgc_bus_model (
  // Device pull-downs
  input wire logic i_scl_oe,
  input wire logic i_sda_oe,
  // Wire levels with pull-ups
  output logic o_scl,
  output logic o_sda
);
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  logic s;
  assign o_scl = m_scl & ~i_scl_oe;
  assign o_sda = m_sda & ~i_sda_oe;
  // ----
  // Master cycles
  // ----
  task clk(output logic v);
    int n;
    #30 m_scl = 1'b1;
    #1;
    for (n = 0; n < 9000 && !o_scl; n++)
      #10;
    #31 v = o_sda;
    #30 m_scl = 1'b0;
    #33;
  endtask : clk
  task start;
    m_sda = 1'b1;
    m_scl = 1'b1;
    #60 m_sda = 1'b0;
    #60 m_scl = 1'b0;
    #30;
  endtask : start
  task stop;
    m_sda = 1'b0;
    #30 m_scl = 1'b1;
    #60 m_sda = 1'b1;
    #60;
  endtask : stop
  task wbyte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      m_sda = v[i];
      clk(s);
    end
    m_sda = 1'b1;
    clk(s);
    ack = ~s;
  endtask : wbyte
  task rbyte(input logic nack, output logic [7:0] v);
    m_sda = 1'b1;
    for (int i = 7; i >= 0; i--)
      clk(v[i]);
    m_sda = nack;
    clk(s);
    m_sda = 1'b1;
  endtask : rbyte
endmodule : ispgc_bus_model

// File: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam logic [11:0] A_ST = ispgc_pkg::ADDR_SERIAL_STATUS;
  localparam logic [11:0] A_BUF = ispgc_pkg::ADDR_SERIAL_BUFFER;
  localparam logic [11:0] A_CTL = ispgc_pkg::ADDR_SERIAL_CONTROL;
  localparam logic [11:0] A_CT2 = ispgc_pkg::ADDR_SERIAL_CONTROL_TWO;
  localparam logic [11:0] A_FLG = ispgc_pkg::ADDR_PERIPHERAL_FLAGS_ONE;
  localparam logic [11:0] A_OWN = ispgc_pkg::ADDR_OWN_ADDRESS;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sleep = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ack;
  logic scl, sda, scl_out, scl_oe, sda_out, sda_oe, wake, free;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0] b, tx;
  logic [6:0] own;
  int n_fail = 0;
  int n_tests = 0;

  always #5 mclk = ~mclk;

  ispgc_slave i_ispgc_slave (
    .i_mclk(mclk), .i_reset(reset), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_scl(scl), .o_scl_out(scl_out),
    .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .i_sleep(sleep), .o_wake(wake), .o_bus_free(free)
  );
  ispgc_bus_model i_ispgc_bus_model (
    .i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda)
  );
  // ----
  // Helpers
  // ----
  function automatic logic [7:0] abyte(input logic [6:0] a, input logic rd);
    return {a, rd};
  endfunction : abyte
  function automatic logic ack_exp(input logic bf, input logic ov);
    return !bf && !ov;
  endfunction : ack_exp
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic axw(input logic [11:0] a, input logic [7:0] v);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 99; n++)
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (!bvalid) n_fail++;
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic rdc(input logic [11:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 99; n++)
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (!rvalid) n_fail++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    chk(d & {24'h000000, m}, {24'h000000, e});
  endtask : rdc
  task summarize;
    $display("Tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // ----
  // Scenarios
  // ----
  initial
  begin
    void'($urandom(32'hb67362d2));
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rdc(A_CTL, 8'hff, 8'h00);
    rdc(A_CT2, 8'hff, 8'h00);
    rdc(A_ST, 8'hff, 8'h00);
    rdc(12'h004, 8'hff, 8'h00);
    chk(r, ispgc_pkg::RESP_SLVERR);
    axw(12'h004, 8'h5a);
    chk(r, ispgc_pkg::RESP_SLVERR);
    own = 7'($urandom_range(103, 8));
    b = 8'($urandom);
    tx = 8'($urandom);
    axw(A_OWN, abyte(own, 1'b0));
    axw(ispgc_pkg::ADDR_PERIPHERAL_ENABLES_ONE, 8'h08);
    axw(A_CTL, 8'h20);
    i_ispgc_bus_model.start();
    i_ispgc_bus_model.wbyte(abyte(own, 1'b0), ack);
    chk(ack, 1'b1);
    rdc(A_ST, 8'h05, 8'h01);
    rdc(A_FLG, 8'h08, 8'h08);
    rdc(A_BUF, 8'hff, abyte(own, 1'b0));
    axw(A_FLG, 8'h00);
    i_ispgc_bus_model.wbyte(b, ack);
    chk(ack, ack_exp(1'b0, 1'b0));
    axw(A_FLG, 8'h00);
    i_ispgc_bus_model.wbyte(tx, ack);
    chk(ack, ack_exp(1'b1, 1'b0));
    rdc(A_FLG, 8'h08, 8'h08);
    rdc(A_BUF, 8'hff, b);
    i_ispgc_bus_model.wbyte(tx, ack);
    chk(ack, ack_exp(1'b0, 1'b1));
    rdc(A_BUF, 8'hff, tx);
    rdc(A_CTL, 8'h40, 8'h40);
    i_ispgc_bus_model.stop();
    @(posedge mclk) sleep <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(wake, 1'b1);
    chk(free, 1'b1);
    axw(A_FLG, 8'h00);
    repeat (3) @(posedge mclk);
    chk(wake, 1'b0);
    sleep <= 1'b0;
    axw(A_CTL, 8'h20);
    for (int g = 0; g < 2; g++)
    begin
      axw(A_CT2, g ? 8'h80 : 8'h00);
      i_ispgc_bus_model.start();
      i_ispgc_bus_model.wbyte(8'h00, ack);
      chk(ack, g);
      rdc(A_ST, 8'h01, 8'(g));
      rdc(A_BUF, 8'hff, g ? 8'h00 : tx);
      i_ispgc_bus_model.stop();
    end
    axw(A_CTL, 8'h21);
    i_ispgc_bus_model.start();
    i_ispgc_bus_model.wbyte(8'h00, ack);
    rdc(A_ST, 8'h02, 8'h00);
    rdc(A_BUF, 8'hff, 8'h00);
    i_ispgc_bus_model.wbyte(b, ack);
    chk(ack, 1'b1);
    rdc(A_BUF, 8'hff, b);
    i_ispgc_bus_model.stop();
    axw(A_OWN, 8'hf0);
    i_ispgc_bus_model.start();
    i_ispgc_bus_model.wbyte(8'hf0, ack);
    chk(ack, 1'b1);
    rdc(A_ST, 8'h02, 8'h02);
    axw(A_OWN, abyte(own, 1'b0));
    rdc(A_BUF, 8'hff, 8'hf0);
    i_ispgc_bus_model.stop();
    axw(A_CTL, 8'h20);
    i_ispgc_bus_model.start();
    i_ispgc_bus_model.wbyte(abyte(own, 1'b1), ack);
    chk(ack, 1'b1);
    rdc(A_ST, 8'h05, 8'h05);
    rdc(A_BUF, 8'hff, abyte(own, 1'b1));
    chk(scl, 1'b0);
    axw(A_FLG, 8'h00);
    axw(A_BUF, tx);
    repeat (20) @(posedge mclk);
    chk(scl, 1'b0);
    axw(A_CTL, 8'h30);
    i_ispgc_bus_model.rbyte(1'b1, b);
    chk(b, tx);
    rdc(A_FLG, 8'h08, 8'h08);
    chk(sda_oe, 1'b0);
    i_ispgc_bus_model.stop();
    axw(A_CTL, 8'h28);
    axw(A_FLG, 8'h00);
    i_ispgc_bus_model.start();
    rdc(A_FLG, 8'h08, 8'h08);
    axw(A_CTL, 8'h20);
    i_ispgc_bus_model.start();
    i_ispgc_bus_model.wbyte(abyte(own, 1'b1), ack);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(scl_oe, 1'b0);
    chk(free, 1'b1);
    rdc(A_CTL, 8'hff, 8'h00);
    rdc(A_ST, 8'h18, 8'h00);
    i_ispgc_bus_model.stop();
    summarize();
  end

  initial
  begin
    #900000;
    n_fail++;
    summarize();
  end
endmodule : tb_top
